// *** mgmt_host_model.sv ***
// host-side pin and serial-line model
`timescale 1ns/10ps
module mgmt_host_model (
    // clock
    input wire logic clk_sys,
    // host pins
    output logic     module_select_n,
    output logic     module_reset_n,
    output logic     low_power_request,
    output logic     scl,
    output logic     sda
);
    // lines idle high as with their pull-ups, clock stands still between frames
    initial begin
        module_select_n = 1'b0;
        module_reset_n = 1'b1;
        low_power_request = 1'b0;
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic set_pins(input logic sel_n, input logic lp);
        module_select_n <= sel_n;
        low_power_request <= lp;
        @(posedge clk_sys);
    endtask
    task automatic pulse_reset(input int n);
        module_reset_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        module_reset_n <= 1'b1;
    endtask
    // start, stop, then a start whose clock fall is the commit point; 40 ns per line step
    task automatic frame();
        logic [11:0] seq;
        seq = 12'hb8b;
        for (int i = 5; i >= 0; i--) begin
            scl <= seq[2*i+1];
            sda <= seq[2*i];
            repeat (10) @(posedge clk_sys);
        end
    endtask
endmodule

// *** mgmt_sideband.sv ***
// sideband management, flag latching, interrupt and power control of a transceiver module
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "mgmt_sideband_regs.svh"
// Behaviour
// - fully functional within 2000 ms of start
// - reset needs low pulse over 2 us
// - serial bus answered within 2000 ms
// - not-ready bit clears, interrupt asserts, within 2000 ms
// - ready shown by interrupt from not-ready clearing
// - low-power request lowers power within 100 us
// - interrupt condition drives output low within 200 ms
// - flags clear on read, interrupt releases within 500 us
// - release timed from clock fall after stop
// - receive loss sets flag and interrupt within 100 ms
// - other conditions set flag and interrupt within 200 ms
// - setting mask inhibits interrupt within 100 ms
// - clearing mask resumes interrupt within 100 ms
// - mask and power-down timed from clock fall after stop
// - select asserted: answer bus within 100 us
// - select released: stop answering within 100 us
// - power-down bit set lowers power within 100 ms
// - power-down bit cleared restores function within 300 ms
// - read-write module and lane mask bytes provided; only the 12-bit lane mask register exists, the ready flag has no mask

module mgmt_sideband
    import mgmt_sideband_pkg::*;
#(
    parameter int unsigned INIT_CYCLES   = `T_INIT_MS * 1000 * `CLK_MHZ,
    parameter int unsigned COMMIT_CYCLES = `T_INT_OFF_US * `CLK_MHZ
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // apb slave
    input  wire logic [7:0]   paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // host-facing pins
    input  wire logic         module_select_n,
    input  wire logic         module_reset_n,
    input  wire logic         low_power_request,
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output logic              interrupt_out_n,
    output logic              module_present_n,
    // module internals
    input  wire lane_events_t lane_events,
    output logic              serial_respond,
    output logic              low_power_state,
    output logic              module_held
);

    localparam int unsigned RESET_MIN_CYCLES = `T_RESET_MIN_US * `CLK_MHZ;
    localparam int unsigned RCW              = $clog2(RESET_MIN_CYCLES + 1);
    localparam int          NPIN             = 5;
    localparam logic [4:0]  PIN_IDLE_LVL     = `PIN_IDLE;

    // pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin_f;
    logic            sel_n_f;
    logic            rst_n_f;
    logic            lp_f;
    logic            scl_f;
    logic            sda_f;

    // control state
    init_state_t     state;
    logic [31:0]     init_cnt;
    logic [RCW-1:0]  rst_low_cnt;
    logic            rst_qualified;
    logic            ready_evt;
    flag_vec_t       flags;
    flag_vec_t       flag_snap;
    lane_events_t    mask_reg;
    lane_events_t    mask_eff;
    logic            pdown_reg;
    logic            pdown_eff;
    logic            pend;
    logic [31:0]     commit_cnt;
    logic            commit;
    logic            scl_prev;
    logic            sda_prev;
    logic            stop_armed;
    logic            stop_fall;
    logic            irq_raw;

    // apb decode
    logic            acc;
    logic            done;
    logic            hit;
    logic            wr_done;
    logic            rd_flags_done;
    logic [31:0]     next_rdata;

    assign pin_raw = {sda_in, scl_in, low_power_request, module_reset_n, module_select_n};

    // three stages; a level is accepted only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    sync1[gi] <= PIN_IDLE_LVL[gi];
                    sync2[gi] <= PIN_IDLE_LVL[gi];
                    sync3[gi] <= PIN_IDLE_LVL[gi];
                    pin_f[gi] <= PIN_IDLE_LVL[gi];
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        pin_f[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    assign sel_n_f = pin_f[0];
    assign rst_n_f = pin_f[1];
    assign lp_f    = pin_f[2];
    assign scl_f   = pin_f[3];
    assign sda_f   = pin_f[4];

    // reset pin low-time qualifier
    always_ff @(posedge clk_sys) begin
        if (rst || rst_n_f) begin
            rst_low_cnt <= '0; // short glitches restart the count
        end else if (rst_low_cnt != RCW'(RESET_MIN_CYCLES)) begin
            rst_low_cnt <= rst_low_cnt + RCW'(1);
        end
    end

    assign rst_qualified = (rst_low_cnt == RCW'(RESET_MIN_CYCLES));

    // initialisation sequence after power on or a qualified reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state     <= st_init;
            init_cnt  <= '0;
            ready_evt <= 1'b0;
        end else begin
            ready_evt <= 1'b0;
            if (rst_qualified) begin
                state    <= st_held;
                init_cnt <= '0;
            end else begin
                unique case (state)
                    st_held: begin
                        if (rst_n_f) begin
                            state <= st_init;
                        end
                    end
                    st_init: begin
                        if (init_cnt >= INIT_CYCLES - 1) begin
                            state     <= st_run;
                            ready_evt <= 1'b1;
                        end else begin
                            init_cnt <= init_cnt + 32'd1;
                        end
                    end
                    st_run: begin
                    end
                endcase
            end
        end
    end

    // apb handshake: one wait state, the transfer completes when pready is seen
    assign acc           = psel && penable && !pready;
    assign done          = psel && penable && pready;
    assign hit           = (paddr == `REG_STATUS) || (paddr == `REG_FLAGS) ||
                           (paddr == `REG_MASK) || (paddr == `REG_CONTROL);
    assign wr_done       = done && pwrite;
    assign rd_flags_done = done && !pwrite && (paddr == `REG_FLAGS);

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            `REG_STATUS: begin
                next_rdata[`ST_NOT_READY]  = (state != st_run);
                next_rdata[`ST_SELECTED]   = !sel_n_f;
                next_rdata[`ST_LOW_POWER]  = low_power_state;
                next_rdata[`ST_IN_RESET]   = (state == st_held);
                next_rdata[`ST_RESPONDING] = serial_respond;
            end
            `REG_FLAGS: begin
                next_rdata[$bits(flag_vec_t)-1:0] = flags;
            end
            `REG_MASK: begin
                next_rdata[$bits(lane_events_t)-1:0] = mask_reg;
            end
            `REG_CONTROL: begin
                next_rdata[`CTL_POWER_DOWN] = pdown_reg;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc && !hit;
        end
    end

    // read data is captured a cycle ahead so prdata is a plain flip-flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (acc) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        end
    end

    // only bits the host actually saw are cleared later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_snap <= '0;
        end else if (acc) begin
            flag_snap <= flags;
        end
    end

    // writable registers; effect on the block waits for the commit point
    always_ff @(posedge clk_sys) begin
        if (rst || state == st_held) begin
            mask_reg <= `MASK_RST;
        end else if (wr_done && paddr == `REG_MASK) begin
            mask_reg <= pwdata[$bits(lane_events_t)-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state == st_held) begin
            pdown_reg <= `POWER_DOWN_RST;
        end else if (wr_done && paddr == `REG_CONTROL) begin
            pdown_reg <= pwdata[`CTL_POWER_DOWN];
        end
    end

    // serial stop detection: sda rises with scl high, then the next scl fall
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_f;
            sda_prev <= sda_f;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stop_armed <= 1'b0;
        end else if (scl_f && scl_prev && sda_f && !sda_prev) begin
            stop_armed <= 1'b1;
        end else if (stop_fall) begin
            stop_armed <= 1'b0;
        end
    end

    assign stop_fall = stop_armed && scl_prev && !scl_f;

    // a pending clear or write commits at the anchor edge, or after a bounded
    // wait so an idle serial clock cannot hold the interrupt or mask forever
    assign commit = pend && (stop_fall || commit_cnt >= COMMIT_CYCLES - 1);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend       <= 1'b0;
            commit_cnt <= '0;
        end else if (rd_flags_done || (wr_done && hit)) begin
            pend       <= 1'b1;
            commit_cnt <= '0;
        end else if (commit) begin
            pend       <= 1'b0;
            commit_cnt <= '0;
        end else if (pend) begin
            commit_cnt <= commit_cnt + 32'd1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state == st_held) begin
            mask_eff <= `MASK_RST;
        end else if (commit) begin
            mask_eff <= mask_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state == st_held) begin
            pdown_eff <= `POWER_DOWN_RST;
        end else if (commit) begin
            pdown_eff <= pdown_reg;
        end
    end

    // latched flags; a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_sys) begin
        if (rst || state == st_held) begin
            flags <= '0;
        end else begin
            flags.ready <= (flags.ready && !(rd_flags_done && flag_snap.ready)) ||
                           ready_evt;
            flags.lane  <= (flags.lane & ~(rd_flags_done ? flag_snap.lane : '0)) |
                           (state == st_run ? lane_events : '0);
        end
    end

    // ready flag cannot be masked; lane flags are gated by the committed mask
    assign irq_raw = flags.ready || |(flags.lane & ~mask_eff);

    // outputs, all registered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            interrupt_out_n <= 1'b1;
        end else begin
            // once low, release waits for the commit point after the clearing read
            interrupt_out_n <= !(irq_raw || (!interrupt_out_n && pend));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            module_present_n <= 1'b1;
        end else begin
            module_present_n <= 1'b0;
        end
    end

    // bus answers are gated off until init ends and while deselected
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_respond <= 1'b0;
        end else begin
            serial_respond <= (state == st_run) && !sel_n_f;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            low_power_state <= 1'b1;
        end else begin
            low_power_state <= lp_f || pdown_eff || (state != st_run);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            module_held <= 1'b0;
        end else begin
            module_held <= (state == st_held);
        end
    end

endmodule

// *** mgmt_sideband_assertions.sv ***
// port-level timing checker of the sideband management block
`timescale 1ns/10ps
`include "mgmt_sideband_regs.svh"
module mgmt_sideband_assertions
    import mgmt_sideband_pkg::*;
#(
    parameter int unsigned INIT_CYCLES   = 200,
    parameter int unsigned COMMIT_CYCLES = 50
) (
    // clock and reset
    input wire logic         clk_sys,
    input wire logic         rst,
    // apb
    input wire logic [7:0]   paddr,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [31:0]  pwdata,
    input wire logic         pready,
    // pins and internals
    input wire logic         module_select_n,
    input wire logic         module_reset_n,
    input wire logic         low_power_request,
    input wire logic         interrupt_out_n,
    input wire lane_events_t lane_events,
    input wire logic         serial_respond,
    input wire logic         low_power_state,
    input wire logic         module_held
);
    localparam int MIN_LOW = `T_RESET_MIN_US * `CLK_MHZ;
    localparam int QUIET   = COMMIT_CYCLES + 4;
    int unsigned init_cnt;
    int unsigned low_run;
    int unsigned since_clr;
    logic [11:0] mask_seen;
    logic        done;
    assign done = psel && penable && pready;
    always_ff @(posedge clk_sys) begin
        if (rst) init_cnt <= 0;
        else if (init_cnt < INIT_CYCLES + 9) init_cnt <= init_cnt + 1;
    end
    always_ff @(posedge clk_sys) begin
        if (rst || module_reset_n) low_run <= 0;
        else if (low_run < 1000) low_run <= low_run + 1;
    end
    // only accesses to the flag or mask register, read or write, may let the interrupt go
    always_ff @(posedge clk_sys) begin
        if (rst || (done && paddr inside {`REG_FLAGS, `REG_MASK})) since_clr <= 0;
        else if (since_clr <= QUIET) since_clr <= since_clr + 1;
    end
    // shadow is only trusted once a commit window has passed
    always_ff @(posedge clk_sys) begin
        if (rst || module_held) mask_seen <= 12'h000;
        else if (done && pwrite && paddr == `REG_MASK) mask_seen <= pwdata[11:0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_sel_low;
        $fell(module_select_n) ##0 (!module_select_n && !low_power_state)[*8];
    endsequence
    sequence s_lp_high;
        $rose(low_power_request) ##0 low_power_request[*8];
    endsequence
    property p_sel_on; s_sel_low |=> serial_respond; endproperty
    a_sel_on: assert property (p_sel_on) else $error("no answer after select");
    property p_sel_off; $rose(module_select_n) |-> ##[1:8] !serial_respond; endproperty
    a_sel_off: assert property (p_sel_off) else $error("answer after deselect");
    property p_lp; s_lp_high |=> low_power_state; endproperty
    a_lp: assert property (p_lp) else $error("low power not entered");
    property p_rst_min; $rose(module_held) |-> low_run >= MIN_LOW; endproperty
    a_rst_min: assert property (p_rst_min) else $error("short reset pulse taken");
    property p_init_int; init_cnt == INIT_CYCLES + 8 |-> !interrupt_out_n; endproperty
    a_init_int: assert property (p_init_int) else $error("no ready interrupt");
    property p_init_bus;
        init_cnt == INIT_CYCLES + 8 |-> serial_respond && !low_power_state;
    endproperty
    a_init_bus: assert property (p_init_bus) else $error("not functional after init");
    property p_int_free;
        $rose(interrupt_out_n) |-> since_clr <= QUIET || module_held || $past(module_held, 2);
    endproperty
    a_int_free: assert property (p_int_free) else $error("interrupt freed unread");
    property p_los;
        lane_events.rx_los != 4'h0 && !low_power_state && mask_seen[3:0] == 4'h0
            && since_clr > QUIET |-> ##[1:3] !interrupt_out_n;
    endproperty
    a_los: assert property (p_los) else $error("receive loss not signalled");
endmodule
bind mgmt_sideband mgmt_sideband_assertions #(
    .INIT_CYCLES(INIT_CYCLES), .COMMIT_CYCLES(COMMIT_CYCLES)
) i_chk (
    .clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .low_power_request(low_power_request),
    .interrupt_out_n(interrupt_out_n), .lane_events(lane_events),
    .serial_respond(serial_respond), .low_power_state(low_power_state),
    .module_held(module_held)
);

// *** mgmt_sideband_pkg.sv ***
// types shared by the sideband management logic
package mgmt_sideband_pkg;

    // per-lane condition inputs, also the layout of the mask register
    typedef struct packed {
        logic [3:0] alarm;
        logic [3:0] tx_fault;
        logic [3:0] rx_los;
    } lane_events_t;

    // latched flags: lane flags plus the ready indication
    typedef struct packed {
        logic         ready;
        lane_events_t lane;
    } flag_vec_t;

    typedef enum logic [1:0] {
        st_held,
        st_init,
        st_run
    } init_state_t;

endpackage

// *** mgmt_sideband_regs.svh ***
// register offsets, field positions, reset values and timing figures of the sideband block
`ifndef MGMT_SIDEBAND_REGS_SVH
`define MGMT_SIDEBAND_REGS_SVH

// apb byte offsets
`define REG_STATUS        8'h00
`define REG_FLAGS         8'h04
`define REG_MASK          8'h08
`define REG_CONTROL       8'h0c

// status fields
`define ST_NOT_READY      0
`define ST_SELECTED       1
`define ST_LOW_POWER      2
`define ST_IN_RESET       3
`define ST_RESPONDING     4

// control fields
`define CTL_POWER_DOWN    0

// reset values
`define MASK_RST          12'h000
`define POWER_DOWN_RST    1'b0
`define PIN_IDLE          5'h1b

// timing figures as specified
`define CLK_MHZ           250
`define T_INIT_MS         2000
`define T_RESET_MIN_US    2
`define T_INT_OFF_US      500

`endif

// *** tb.sv ***
// self-checking bench of the sideband management block
`timescale 1ns/10ps
`include "mgmt_sideband_regs.svh"
module tb;
    import mgmt_sideband_pkg::*;
    localparam int INIT   = 200;
    localparam int COMMIT = 200;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   paddr = 8'h00;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, err, sel_n, rst_n, lp_req, scl, sda;
    logic         int_n, prs_n, respond, lp_state, held;
    lane_events_t events = 12'h000;
    int           err_total = 0;
    int           num_checks = 0;
    int           cycles = 0;
    always #2 clk_sys = ~clk_sys;
    mgmt_sideband #(.INIT_CYCLES(INIT), .COMMIT_CYCLES(COMMIT)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .module_select_n(sel_n), .module_reset_n(rst_n), .low_power_request(lp_req),
        .scl_in(scl), .sda_in(sda), .interrupt_out_n(int_n), .module_present_n(prs_n),
        .lane_events(events), .serial_respond(respond), .low_power_state(lp_state),
        .module_held(held)
    );
    mgmt_host_model i_host (
        .clk_sys(clk_sys), .module_select_n(sel_n), .module_reset_n(rst_n),
        .low_power_request(lp_req), .scl(scl), .sda(sda)
    );
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask
    // entered just after an edge; the request is held until pready is sampled
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic wait_int(input logic lvl, input int lim);
        int n;
        n = 0;
        while (int_n !== lvl && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk_bit("interrupt_out_n", lvl, int_n);
    endtask
    task automatic pulse_events(input logic [11:0] v);
        events <= v;
        @(posedge clk_sys);
        events <= 12'h000;
        @(posedge clk_sys);
    endtask
    task automatic t_init();
        repeat (INIT + 10) @(posedge clk_sys);
        wait_int(1'b0, 0);
        chk_bit("serial_respond", 1'b1, respond);
        chk_bit("module_present_n", 1'b0, prs_n);
        rd_chk("status", `REG_STATUS, 32'h12);
        rd_chk("flags", `REG_FLAGS, 32'h1000);
        i_host.frame();
        wait_int(1'b1, 0);
        $display("init test done");
    endtask
    task automatic t_flags();
        repeat (COMMIT + 10) @(posedge clk_sys);
        pulse_events(12'h001);
        pulse_events(12'h010);
        wait_int(1'b0, 3);
        rd_chk("flags", `REG_FLAGS, 32'h011);
        rd_chk("flags", `REG_FLAGS, 32'h000);
        wait_int(1'b1, COMMIT + 10);
        $display("flag test done");
    endtask
    task automatic t_mask();
        apb(`REG_MASK, 1'b1, 32'hffff_ffff);
        rd_chk("mask", `REG_MASK, 32'h0fff);
        i_host.frame();
        pulse_events(12'h100);
        repeat (5) @(posedge clk_sys);
        wait_int(1'b1, 0);
        apb(`REG_MASK, 1'b1, 32'h0);
        i_host.frame();
        wait_int(1'b0, 0);
        rd_chk("flags", `REG_FLAGS, 32'h100);
        i_host.frame();
        wait_int(1'b1, 0);
        $display("mask test done");
    endtask
    task automatic t_power();
        apb(`REG_CONTROL, 1'b1, 32'h1);
        i_host.frame();
        chk_bit("low_power_state", 1'b1, lp_state);
        rd_chk("control", `REG_CONTROL, 32'h1);
        apb(`REG_CONTROL, 1'b1, 32'h0);
        i_host.frame();
        chk_bit("low_power_state", 1'b0, lp_state);
        i_host.set_pins(1'b0, 1'b1);
        repeat (10) @(posedge clk_sys);
        chk_bit("low_power_state", 1'b1, lp_state);
        i_host.set_pins(1'b0, 1'b0);
        $display("power test done");
    endtask
    task automatic t_select();
        i_host.set_pins(1'b1, 1'b0);
        repeat (10) @(posedge clk_sys);
        chk_bit("serial_respond", 1'b0, respond);
        rd_chk("status", `REG_STATUS, 32'h0);
        i_host.set_pins(1'b0, 1'b0);
        repeat (10) @(posedge clk_sys);
        chk_bit("serial_respond", 1'b1, respond);
        rd_chk("unmapped", 8'h10, 32'h0);
        chk_bit("pslverr", 1'b1, err);
        $display("select test done");
    endtask
    task automatic t_pin_reset();
        apb(`REG_MASK, 1'b1, 32'h0a5);
        i_host.pulse_reset(100);
        repeat (10) @(posedge clk_sys);
        chk_bit("module_held", 1'b0, held);
        rd_chk("mask", `REG_MASK, 32'h0a5);
        i_host.pulse_reset(600);
        chk_bit("module_held", 1'b1, held);
        wait_int(1'b0, INIT + 30);
        rd_chk("mask", `REG_MASK, 32'h0);
        $display("pin reset test done");
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_init();
        t_flags();
        t_mask();
        t_power();
        t_select();
        t_pin_reset();
        wrap_up();
    end
endmodule
